/* File: verilog/ccrg_pkg.sv */
/*
 * ccrg_pkg: constants for the core control register bank
 * (change guard, stack pointer, status flags, pointer pairs).
 * Assumes a byte-wide I/O register port driven by the core.
 */
package ccrg_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] OFS_GUARD_KEY = 6'h04;
	localparam logic [5:0] OFS_SP_LOW    = 6'h0D;
	localparam logic [5:0] OFS_SP_HIGH   = 6'h0E;
	localparam logic [5:0] OFS_STATUS    = 6'h0F;
	// ------------------------------------------------------------
	// key values and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_IO_UNLOCK       = 8'hD8;
	localparam logic [7:0] KEY_SELFPROG_UNLOCK = 8'h9D;
	localparam logic [7:0] STATUS_RESET        = 8'h00;
	// top of internal memory, sets stack pointer reset value
	localparam logic [15:0] SRAM_TOP = 16'h3FFF;
	localparam int          SP_BITS  = 14;
	localparam logic [15:0] SP_MASK  = 16'h3FFF;
	// ------------------------------------------------------------
	// status field positions
	// ------------------------------------------------------------
	localparam int BIT_I = 7;
	localparam int BIT_T = 6;
	localparam int BIT_H = 5;
	localparam int BIT_S = 4;
	localparam int BIT_V = 3;
	localparam int BIT_N = 2;
	localparam int BIT_Z = 1;
	localparam int BIT_C = 0;
	// guard window length in executed instructions
	localparam logic [2:0] GUARD_INSNS = 3'h4;
	// pointer pair addressing modes
	typedef enum logic [1:0] {CCRG_PTR_PLAIN, CCRG_PTR_POSTINC, CCRG_PTR_PREDEC, CCRG_PTR_DISP} ccrg_ptr_mode_e;
endpackage : ccrg_pkg

/* File: verilog/ccrg_regs.sv */
/*
 * ccrg_regs: control register bank of a small core.
 * Holds change guard windows, stack pointer, status flags and the
 * three 16-bit pointer pairs. Assumes the core reports each retired
 * instruction, each memory class access and its ALU flag results.
 */
//
// Contract
// - io key write opens io window
// - selfprog key opens nvm command window
// - io window closes on memory/nvm/sleep
// - selfprog window closes on nvm/sleep
// - open window blocks all interrupt service
// - service resumes when window ends
// - key reads show window status bits
// - stack pointer resets to memory top
// - unused stack pointer bits read zero
// - stack pointer is two byte registers
// - low byte write blocks interrupts briefly
// - bit seven is global interrupt enable
// - entry and return leave enable alone
// - enable change adds one wait cycle; here only a status register write waits, sei/cli change it with no wait
// - transfer bit for bit ops
// - half carry from low nibble
// - overflow flag from arithmetic
// - sign equals negative xor overflow
// - negative zero carry follow result
// - registers 26-31 form three pointers
// - pointers support displacement, increments, program
// - no automatic status save on interrupts
`timescale 1ns/1ps
module ccrg_regs (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	// i/o register port
	input  wire logic [5:0]  io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_wait,
	// core event reports
	input  wire logic        insn_retire,
	input  wire logic        mem_write,
	input  wire logic        nvm_access,
	input  wire logic        sleep_exec,
	input  wire logic        nvm_cmd_write,
	// stack adjust from push/pop/call/ret
	input  wire logic        sp_adj,
	input  wire logic [15:0] sp_new,
	// alu flag update
	input  wire logic        alu_upd,
	input  wire logic        alu_arith,
	input  wire logic [7:0]  alu_result,
	input  wire logic        alu_carry,
	input  wire logic        alu_half,
	input  wire logic        alu_ovf,
	input  wire logic        bit_store_op,
	input  wire logic        bit_store_val,
	input  wire logic        sei_op,
	input  wire logic        cli_op,
	// working register writes to r26..r31
	input  wire logic        wreg_wr,
	input  wire logic [4:0]  wreg_idx,
	input  wire logic [7:0]  wreg_data,
	// pointer use by load/store
	input  wire logic        ptr_use,
	input  wire logic [1:0]  ptr_sel,
	input  wire ccrg_pkg::ccrg_ptr_mode_e ptr_mode,
	input  wire logic [5:0]  ptr_disp,
	input  wire logic        irq_pending,
	output logic      [15:0] ptr_addr,
	output logic      [15:0] prog_addr,
	output logic             nvm_cmd_allow,
	output logic             irq_take_ok,
	output logic             transfer_bit,
	output logic      [15:0] stack_pointer,
	output logic      [7:0]  status_flags
);
	// ------------------------------------------------------------
	// local state
	// ------------------------------------------------------------
	logic [2:0]  io_cnt_r;
	logic [2:0]  spm_cnt_r;
	logic [2:0]  spl_cnt_r;
	logic [15:0] sp_r;
	logic [7:0]  sr_r;
	logic [7:0]  ptr_r [0:5];
	logic        wait_r;
	logic        key_wr;
	logic        spl_wr;
	logic        sph_wr;
	logic        sr_wr;
	logic        io_open;
	logic        spm_open;
	logic [15:0] ptr_cur;
	logic [15:0] ptr_upd;
	logic [7:0]  rd_mux;

	// access decode
	always_comb begin
		key_wr = io_wr && (io_addr == ccrg_pkg::OFS_GUARD_KEY);
		spl_wr = io_wr && (io_addr == ccrg_pkg::OFS_SP_LOW);
		sph_wr = io_wr && (io_addr == ccrg_pkg::OFS_SP_HIGH);
		sr_wr  = io_wr && (io_addr == ccrg_pkg::OFS_STATUS);
		io_open  = (io_cnt_r != 3'h0);
		spm_open = (spm_cnt_r != 3'h0);
	end

	// ------------------------------------------------------------
	// change guard windows
	// ------------------------------------------------------------
	// io window open
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			io_cnt_r <= 3'h0;
		end else if (clk_en) begin
			if (key_wr && io_wdata == ccrg_pkg::KEY_IO_UNLOCK) begin
				io_cnt_r <= ccrg_pkg::GUARD_INSNS;
			// the protected write itself is a memory write and ends it
			end else if ((mem_write && !key_wr) || nvm_access || sleep_exec) begin
				io_cnt_r <= 3'h0;
			end else if (insn_retire && io_open) begin
				io_cnt_r <= io_cnt_r - 3'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			spm_cnt_r <= 3'h0;
		end else if (clk_en) begin
			if (key_wr && io_wdata == ccrg_pkg::KEY_SELFPROG_UNLOCK) begin
				spm_cnt_r <= ccrg_pkg::GUARD_INSNS;
			end else if (nvm_access || sleep_exec) begin
				spm_cnt_r <= 3'h0;
			end else if (insn_retire && spm_open) begin
				spm_cnt_r <= spm_cnt_r - 3'h1;
			end
		end
	end

	// stack low write hold-off, ended by next i/o write
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			spl_cnt_r <= 3'h0;
		end else if (clk_en) begin
			if (spl_wr) begin
				spl_cnt_r <= ccrg_pkg::GUARD_INSNS;
			end else if (io_wr) begin
				spl_cnt_r <= 3'h0;
			end else if (insn_retire && spl_cnt_r != 3'h0) begin
				spl_cnt_r <= spl_cnt_r - 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// stack pointer
	// ------------------------------------------------------------
	// reset to top
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sp_r <= ccrg_pkg::SRAM_TOP;
		end else if (clk_en) begin
			if (spl_wr) begin
				sp_r <= {sp_r[15:8], io_wdata} & ccrg_pkg::SP_MASK;
			end else if (sph_wr) begin
				sp_r <= {io_wdata, sp_r[7:0]} & ccrg_pkg::SP_MASK;
			end else if (sp_adj) begin
				sp_r <= sp_new & ccrg_pkg::SP_MASK;
			end
		end
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	// nothing here reacts to interrupt entry or return
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sr_r <= ccrg_pkg::STATUS_RESET;
		end else if (clk_en) begin
			if (sr_wr) begin
				sr_r <= io_wdata;
				sr_r[ccrg_pkg::BIT_S] <= io_wdata[ccrg_pkg::BIT_N] ^ io_wdata[ccrg_pkg::BIT_V];
			end else begin
				if (sei_op) begin
					sr_r[ccrg_pkg::BIT_I] <= 1'b1;
				end else if (cli_op) begin
					sr_r[ccrg_pkg::BIT_I] <= 1'b0;
				end
				if (bit_store_op) begin
					sr_r[ccrg_pkg::BIT_T] <= bit_store_val;
				end
				if (alu_upd) begin
					sr_r[ccrg_pkg::BIT_N] <= alu_result[7];
					sr_r[ccrg_pkg::BIT_Z] <= (alu_result == 8'h00);
					sr_r[ccrg_pkg::BIT_C] <= alu_carry;
					sr_r[ccrg_pkg::BIT_H] <= alu_arith ? alu_half : sr_r[ccrg_pkg::BIT_H];
					sr_r[ccrg_pkg::BIT_V] <= alu_arith & alu_ovf;
					sr_r[ccrg_pkg::BIT_S] <= alu_result[7] ^ (alu_arith & alu_ovf);
				end
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wait_r <= 1'b0;
		end else if (clk_en) begin
			wait_r <= sr_wr && !wait_r && (io_wdata[ccrg_pkg::BIT_I] != sr_r[ccrg_pkg::BIT_I]);
		end
	end

	// ------------------------------------------------------------
	// pointer pairs r26..r31
	// ------------------------------------------------------------
	// low register is low byte
	always_comb begin
		ptr_cur = {ptr_r[{ptr_sel, 1'b1}], ptr_r[{ptr_sel, 1'b0}]};
		case (ptr_mode)
			ccrg_pkg::CCRG_PTR_POSTINC: ptr_upd = ptr_cur + 16'h0001;
			ccrg_pkg::CCRG_PTR_PREDEC:  ptr_upd = ptr_cur - 16'h0001;
			default:                    ptr_upd = ptr_cur;
		endcase
	end

	// one register per entry; writeback of modified pointer
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_ptr
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					ptr_r[gi] <= 8'h00;
				end else if (clk_en) begin
					if (wreg_wr && wreg_idx == 5'(26 + gi)) begin
						ptr_r[gi] <= wreg_data;
					end else if (ptr_use && ({ptr_sel, 1'b0} == 3'(gi & 6))
							&& (ptr_mode == ccrg_pkg::CCRG_PTR_POSTINC
							|| ptr_mode == ccrg_pkg::CCRG_PTR_PREDEC)) begin
						ptr_r[gi] <= (gi % 2 == 1) ? ptr_upd[15:8] : ptr_upd[7:0];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read mux and outputs
	// ------------------------------------------------------------
	// key register read
	always_comb begin
		if (io_addr == ccrg_pkg::OFS_GUARD_KEY) begin
			rd_mux = {6'h00, spm_open, io_open};
		end else if (io_addr == ccrg_pkg::OFS_SP_LOW) begin
			rd_mux = sp_r[7:0];
		end else if (io_addr == ccrg_pkg::OFS_SP_HIGH) begin
			rd_mux = sp_r[15:8];
		end else if (io_addr == ccrg_pkg::OFS_STATUS) begin
			rd_mux = sr_r;
		end else begin
			rd_mux = 8'h00;
		end
	end

	// registered outputs; one cycle behind the state they show
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			io_rdata      <= 8'h00;
			io_wait       <= 1'b0;
			ptr_addr      <= 16'h0000;
			prog_addr     <= 16'h0000;
			nvm_cmd_allow <= 1'b0;
			irq_take_ok   <= 1'b0;
			transfer_bit  <= 1'b0;
			stack_pointer <= ccrg_pkg::SRAM_TOP;
			status_flags  <= ccrg_pkg::STATUS_RESET;
		end else if (clk_en) begin
			io_rdata      <= io_rd ? rd_mux : 8'h00;
			io_wait       <= sr_wr && !wait_r && (io_wdata[ccrg_pkg::BIT_I] != sr_r[ccrg_pkg::BIT_I]);
			// displacement form and program memory via third pair
			ptr_addr      <= (ptr_mode == ccrg_pkg::CCRG_PTR_DISP) ? ptr_cur + {10'h000, ptr_disp}
				: (ptr_mode == ccrg_pkg::CCRG_PTR_PREDEC) ? ptr_upd : ptr_cur;
			prog_addr     <= {ptr_r[5], ptr_r[4]};
			nvm_cmd_allow <= spm_open && !nvm_cmd_write;
			irq_take_ok   <= irq_pending && sr_r[ccrg_pkg::BIT_I] && !io_open && !spm_open
				&& (spl_cnt_r == 3'h0);
			transfer_bit  <= sr_r[ccrg_pkg::BIT_T];
			stack_pointer <= sp_r;
			status_flags  <= sr_r;
		end
	end
endmodule : ccrg_regs

/* File: test/ccrg_regs_props.sv */
/* ccrg_regs_props: assertion checker bound into ccrg_regs.
   Assumes one clock domain and arst_n asynchronous, active low. */
`timescale 1ns/1ps
module ccrg_regs_chk (
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic        clk_en,
	input wire logic [5:0]  io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_wdata,
	input wire logic [7:0]  io_rdata,
	input wire logic        io_wait,
	input wire logic        nvm_access,
	input wire logic        sleep_exec,
	input wire logic        nvm_cmd_allow,
	input wire logic        irq_take_ok,
	input wire logic [15:0] stack_pointer,
	input wire logic [7:0]  status_flags
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// ------------------------------
	// properties
	// ------------------------------
	// key write of any value; a new key may reopen a window
	wire logic key_wr = clk_en && io_wr && io_addr == 6'h04;
	property p_key_hi; clk_en && io_rd && io_addr == 6'h04 |=> io_rdata[7:2] == 6'h00; endproperty
	a_key_hi: assert property (p_key_hi) else $error("key high bits set");
	property p_spm_open; key_wr && io_wdata == 8'h9D && !nvm_access && !sleep_exec |=> ##1 nvm_cmd_allow; endproperty
	a_spm_open: assert property (p_spm_open) else $error("selfprog window shut");
	property p_spm_shut; clk_en && (nvm_access || sleep_exec) && !key_wr |=> ##1 !nvm_cmd_allow; endproperty
	a_spm_shut: assert property (p_spm_shut) else $error("selfprog window left open");
	property p_win_irq; nvm_cmd_allow |-> !irq_take_ok; endproperty
	a_win_irq: assert property (p_win_irq) else $error("service inside window");
	property p_ie_gate; !status_flags[7] |-> !irq_take_ok; endproperty
	a_ie_gate: assert property (p_ie_gate) else $error("service with enable clear");
	// enable change waits
	// status_flags lags the register a cycle, so the old enable is read one edge later
	property p_ie_wait; (clk_en && io_wr && io_addr == 6'h0F && !io_wait)
		##1 ($past(io_wdata[7]) != status_flags[7]) |-> io_wait; endproperty
	a_ie_wait: assert property (p_ie_wait) else $error("no wait on enable change");
	property p_sp_bits; (stack_pointer & ~ccrg_pkg::SP_MASK) == 16'h0000; endproperty
	a_sp_bits: assert property (p_sp_bits) else $error("unused stack bits set");
	property p_sign; status_flags[4] == (status_flags[2] ^ status_flags[3]); endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");
endmodule : ccrg_regs_chk
bind ccrg_regs ccrg_regs_chk u_chk (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_wait(io_wait),
	.nvm_access(nvm_access), .sleep_exec(sleep_exec), .nvm_cmd_allow(nvm_cmd_allow),
	.irq_take_ok(irq_take_ok), .stack_pointer(stack_pointer), .status_flags(status_flags));

/* File: test/ccrg_regs_tb.sv */
/* ccrg_regs_tb: self-checking bench for ccrg_regs with a flag and pointer model.
   Assumes ccrg_pkg and the bound checker are compiled first. */
`timescale 1ns/1ps
module ccrg_regs_tb;
	// ------------------------------
	// nets and model state
	// ------------------------------
	logic        clock, arst_n, clk_en, io_wr, io_rd, io_wait, insn_retire, mem_write, nvm_access, sleep_exec;
	logic        nvm_cmd_write, sp_adj, alu_upd, alu_arith, alu_carry, alu_half, alu_ovf, bit_store_op;
	logic        bit_store_val, sei_op, cli_op, wreg_wr, ptr_use, irq_pending, nvm_cmd_allow, irq_take_ok;
	logic        transfer_bit, vv;
	logic [1:0]  ptr_sel;
	logic [4:0]  wreg_idx;
	logic [5:0]  io_addr, ptr_disp;
	logic [7:0]  io_wdata, io_rdata, alu_result, wreg_data, status_flags, m_sr, a, b;
	logic [8:0]  s;
	logic [15:0] sp_new, ptr_addr, prog_addr, stack_pointer, v;
	logic [15:0] m_ptr [3];
	logic [5:0]  closers [5] = '{6'h10, 6'h08, 6'h04, 6'h08, 6'h04};
	int          mismatches, n_compared, cycles, seed;
	ccrg_pkg::ccrg_ptr_mode_e ptr_mode;
	ccrg_regs u_dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_wait(io_wait), .insn_retire(insn_retire),
		.mem_write(mem_write), .nvm_access(nvm_access), .sleep_exec(sleep_exec), .nvm_cmd_write(nvm_cmd_write),
		.sp_adj(sp_adj), .sp_new(sp_new), .alu_upd(alu_upd), .alu_arith(alu_arith), .alu_result(alu_result),
		.alu_carry(alu_carry), .alu_half(alu_half), .alu_ovf(alu_ovf), .bit_store_op(bit_store_op),
		.bit_store_val(bit_store_val), .sei_op(sei_op), .cli_op(cli_op), .wreg_wr(wreg_wr), .wreg_idx(wreg_idx),
		.wreg_data(wreg_data), .ptr_use(ptr_use), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .ptr_disp(ptr_disp),
		.irq_pending(irq_pending), .ptr_addr(ptr_addr), .prog_addr(prog_addr), .nvm_cmd_allow(nvm_cmd_allow),
		.irq_take_ok(irq_take_ok), .transfer_bit(transfer_bit), .stack_pointer(stack_pointer),
		.status_flags(status_flags));
	// clock and hang guard; the run needs well under a thousand cycles
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// event pulses {retire, mem_write, nvm, sleep, sei, cli}, one idle cycle after
	task automatic ev(input logic [5:0] e);
		@(negedge clock) {insn_retire, mem_write, nvm_access, sleep_exec, sei_op, cli_op} = e;
		@(negedge clock) {insn_retire, mem_write, nvm_access, sleep_exec, sei_op, cli_op} = 6'h00;
	endtask : ev
	// one i/o strobe; read data is settled at the return
	task automatic io(input logic wr, input logic [5:0] ad, input logic [7:0] d);
		@(negedge clock) {io_wr, io_rd, io_addr, io_wdata} = {wr, !wr, ad, d};
		@(negedge clock) {io_wr, io_rd} = 2'b00;
	endtask : io
	task automatic rd(input logic [5:0] ad, input logic [7:0] exp);
		io(1'b0, ad, 8'h00);
		chk(io_rdata, exp);
	endtask : rd
	task automatic report_and_stop();
		if (mismatches == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		{io_wr, io_rd, io_addr, io_wdata, nvm_cmd_write, sp_adj, sp_new, arst_n} = '0;
		{insn_retire, mem_write, nvm_access, sleep_exec, sei_op, cli_op, alu_upd, alu_arith, alu_result} = '0;
		{alu_carry, alu_half, alu_ovf, bit_store_op, bit_store_val, wreg_wr, wreg_idx, wreg_data} = '0;
		{ptr_use, ptr_sel, ptr_disp} = '0;
		ptr_mode = ccrg_pkg::CCRG_PTR_PLAIN;
		clk_en = 1'b1;
		irq_pending = 1'b1;
		seed = 32'hb7a0;
		repeat (6) @(negedge clock);
		arst_n = 1'b1;
		chk(stack_pointer, 16'h3FFF);
		chk(status_flags, 8'h00);
		rd(6'h04, 8'h00);
		// enable by register write: costs a wait cycle
		io(1'b1, 6'h0F, 8'h80);
		chk(io_wait, 1'b1);
		rd(6'h0F, 8'h80);
		chk(irq_take_ok, 1'b1);
		m_sr = 8'h80;
		// both keys; three retires keep the window, the fourth ends it
		for (int k = 0; k < 2; k++) begin
			io(1'b1, 6'h04, k[0] ? 8'h9D : 8'hD8);
			repeat (3) ev(6'h20);
			rd(6'h04, k[0] ? 8'h02 : 8'h01);
			chk(irq_take_ok, 1'b0);
			chk(nvm_cmd_allow, k[0]);
			ev(6'h20);
			@(negedge clock);
			chk(irq_take_ok, 1'b1);
			rd(6'h04, 8'h00);
		end
		io(1'b1, 6'h04, 8'hAA);
		rd(6'h04, 8'h00);
		// each closing event ends its window at once
		for (int i = 0; i < 5; i++) begin
			io(1'b1, 6'h04, i < 3 ? 8'hD8 : 8'h9D);
			ev(closers[i]);
			rd(6'h04, 8'h00);
		end
		// random stack values; the high byte write ends the hold-off
		repeat (3) begin
			v = 16'($random(seed));
			io(1'b1, 6'h0D, v[7:0]);
			@(negedge clock);
			chk(irq_take_ok, 1'b0);
			io(1'b1, 6'h0E, v[15:8]);
			@(negedge clock);
			chk(irq_take_ok, 1'b1);
			chk(stack_pointer, v & 16'h3FFF);
			rd(6'h0E, v[15:8] & 8'h3F);
		end
		// core stack adjust keeps only the implemented bits
		sp_new = 16'($random(seed));
		@(negedge clock) sp_adj = 1'b1;
		@(negedge clock) sp_adj = 1'b0;
		@(negedge clock);
		chk(stack_pointer, sp_new & 16'h3FFF);
		io(1'b1, 6'h0D, 8'h5A);
		repeat (4) ev(6'h20);
		@(negedge clock);
		chk(irq_take_ok, 1'b1);
		// random results, odd passes arithmetic; logic keeps half carry
		for (int i = 0; i < 8; i++) begin
			{a, b} = 16'($random(seed));
			s = {1'b0, a} + {1'b0, b};
			vv = i[0] & (a[7] == b[7]) & (s[7] != a[7]);
			@(negedge clock);
			{alu_upd, alu_arith, alu_result, alu_carry, alu_half} = {1'b1, i[0], s[7:0], s[8], a[4] ^ b[4] ^ s[4]};
			{alu_ovf, bit_store_op, bit_store_val} = {vv, 1'b1, s[0]};
			@(negedge clock);
			{alu_upd, bit_store_op} = 2'b00;
			m_sr = {1'b1, s[0], i[0] ? a[4] ^ b[4] ^ s[4] : m_sr[5], s[7] ^ vv, vv, s[7], s[7:0] == 8'h00, s[8]};
			@(negedge clock);
			chk(status_flags, m_sr);
			chk(transfer_bit, s[0]);
		end
		// enable low freezes state: a status write and a set-enable are both lost
		clk_en = 1'b0;
		io(1'b1, 6'h0F, 8'h00);
		ev(6'h02);
		clk_en = 1'b1;
		chk(status_flags, m_sr);
		ev(6'h01);
		@(negedge clock);
		chk(irq_take_ok, 1'b0);
		// pointer pairs, low byte in the even register
		for (int r = 26; r < 32; r++) begin
			v[7:0] = 8'($random(seed));
			m_ptr[(r - 26) / 2][(r % 2) * 8 +: 8] = v[7:0];
			@(negedge clock) {wreg_wr, wreg_idx, wreg_data} = {1'b1, 5'(r), v[7:0]};
			@(negedge clock) wreg_wr = 1'b0;
		end
		@(negedge clock);
		chk(prog_addr, m_ptr[2]);
		for (int i = 0; i < 12; i++) begin
			@(negedge clock) {ptr_use, ptr_sel, ptr_disp} = {1'b1, 2'(i % 3), 6'($random(seed))};
			ptr_mode = ccrg_pkg::ccrg_ptr_mode_e'(i / 3);
			if (i / 3 == 2) m_ptr[i % 3]--;
			@(negedge clock) ptr_use = 1'b0;
			chk(ptr_addr, m_ptr[i % 3] + (i / 3 == 3 ? 16'(ptr_disp) : 16'h0000));
			if (i / 3 == 1) m_ptr[i % 3]++;
		end
		report_and_stop();
	end
endmodule : ccrg_regs_tb
